// file: src/icu_pkg.sv
// Constants, types and register map of the instruction control unit
package icu_pkg;
  // Instruction word field placement
  localparam int ADDR_LSB = 0;
  localparam int IND_BIT = 16;
  localparam int XSEL_LSB = 17;
  localparam int CMD_LSB = 20;
  // Command code layout
  localparam int CLS_LSB = 10;
  localparam int BASIC_LSB = 4;
  localparam int MOD_IMM = 3;
  localparam int MOD_UNNORM = 2;
  localparam int MOD_SAVE = 1;
  localparam int MOD_CPL = 0;
  localparam logic [1:0] CLS_ARITH = 2'h0;
  localparam logic [1:0] CLS_LOGIC = 2'h1;
  localparam logic [1:0] CLS_FLAG = 2'h2;
  localparam logic [1:0] CLS_CTRL = 2'h3;
  // Flag and control operations (basic op field)
  localparam logic [5:0] OP_TEST = 6'h00;
  localparam logic [5:0] OP_SETF = 6'h01;
  localparam logic [5:0] OP_RSTF = 6'h02;
  localparam logic [5:0] OP_STF = 6'h03;
  localparam logic [5:0] OP_LDF = 6'h04;
  localparam logic [5:0] OP_SENSE = 6'h05;
  localparam logic [5:0] OP_FUNC = 6'h00;
  localparam logic [5:0] OP_LINK = 6'h01;
  // Flag register bit positions
  localparam int F_NULL = 0;
  localparam int F_POS = 1;
  localparam int F_NEG = 2;
  localparam int F_EXCESS = 3;
  localparam int F_MSB_OUT = 4;
  localparam int F_WAIT = 5;
  localparam int F_IRQ_ON = 6;
  localparam int F_PROG_LSB = 8;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] PC_RST = 16'h0000;
  // Interrupt vector bases and fixed lines
  localparam logic [15:0] INT_VEC = 16'h0020;
  localparam logic [15:0] EXT_VEC = 16'h0031;
  localparam int LINE_POWER = 0;
  localparam int LINE_PARITY = 1;
  // APB register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PC = 8'h04;
  localparam logic [7:0] A_OPWORD = 8'h08;
  localparam logic [7:0] A_FLAGS = 8'h0c;
  localparam logic [7:0] A_IMASK = 8'h10;
  localparam logic [7:0] A_EMASK = 8'h14;
  localparam logic [7:0] A_EGRP = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1c;

  typedef struct packed {
    logic [11:0] command_code;
    logic [31:0] operand;
    logic [15:0] eff_addr;
    logic [4:0] byte_pos;
    logic unnorm;
    logic save_acc;
  } exec_cmd_s;

  typedef struct packed {
    logic [31:0] acc;
    logic overflow;
    logic carry;
  } exec_res_s;
endpackage : icu_pkg

// file: src/instruction_control_unit.sv
// Instruction sequencing, decode, addressing, flags and interrupt entry
`timescale 1ns/1ps
// What this block does
// RULE_01 - split word into address, indirect, index, command
// RULE_02 - run sequentially with opword and next_pc
// RULE_03 - immediate mode uses address part as operand
// RULE_04 - immediate operands and shifts are signed
// RULE_05 - command bits pick immediate and byte position
// RULE_06 - control ops address sense or function lines
// RULE_07 - multi-level indirection before operand fetch
// RULE_08 - effective address is index plus address part
// RULE_09 - selector zero means no indexing
// RULE_10 - indexing applied at every indirect level
// RULE_11 - command is basic operation plus modifier
// RULE_12 - unnormalized and save-accumulator modifiers
// RULE_13 - sixteen flags reflect end-of-instruction state
// RULE_14 - test, set, reset, branch, complement test
// RULE_15 - null, pos, neg from accumulator sign
// RULE_16 - sticky excess, msb_out is top carry
// RULE_17 - wait_state, irq_on, eight console flags
// RULE_18 - sense test reports high line on null
// RULE_19 - program can store the flag register
// RULE_20 - sixteen internal, 256 external interrupt lines
// RULE_21 - fixed priority, power first, parity next
// RULE_22 - interrupt between instructions, fetch errors early
// RULE_23 - irq_on gates all but power failure
// RULE_24 - fixed field placement in the word
module instruction_control_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory bank port
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_parity_err,
  // Arithmetic datapath
  output logic exec_start,
  output icu_pkg::exec_cmd_s exec_cmd,
  input wire logic exec_done,
  input wire icu_pkg::exec_res_s exec_res,
  input wire logic [15:0] acc_index,
  // Sense and function lines, I/O bus
  output logic io_strobe,
  output logic [15:0] io_addr,
  input wire logic sense_level,
  input wire logic io_busy,
  // Interrupt lines and console
  input wire logic [15:0] int_lines,
  input wire logic [255:0] ext_lines,
  input wire logic [7:0] console_flags,
  output logic int_ack,
  output logic [8:0] int_id
);
  import icu_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_INTCHK, S_FETCH, S_INDEX, S_INDIR, S_DISP,
    S_OPND, S_EXEC, S_WRITE
  } state_e;

  typedef struct packed {
    state_e st;
    logic run;
    logic trap;
    logic [15:0] next_pc;
    logic [31:0] opword;
    logic [15:0] ea;
    logic [2:0] xsel;
    logic ind;
    logic [15:0] flags;
    logic [15:0] imask;
    logic [15:0] emask;
    logic [15:0] egrp;
    logic mem_req;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [31:0] mem_wdata;
    logic exec_start;
    exec_cmd_s cmd;
    logic io_strobe;
    logic int_ack;
    logic [8:0] int_id;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;

  state_s r_reg, r_next;

  // RULE_01 field split
  // RULE_24 fixed bit positions
  logic [11:0] cmd_code;
  logic [1:0] cls;
  logic [5:0] basic;
  logic [15:0] addr_part;
  assign cmd_code = r_reg.opword[CMD_LSB +: 12];
  assign cls = cmd_code[CLS_LSB +: 2];
  assign basic = cmd_code[BASIC_LSB +: 6];
  assign addr_part = r_reg.opword[ADDR_LSB +: 16];

  // Lowest-numbered active line wins in each group
  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] idx;
    idx = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : first_set

  // RULE_20 per-group request vectors
  logic [16:0] grp_any;
  logic [15:0] grp_vec [17];
  genvar g;
  generate
    for (g = 0; g < 17; g++) begin : gen_grp
      if (g == 0) begin : gen_int
        // RULE_23 power line bypasses enable
        assign grp_vec[g] = int_lines & r_reg.imask &
          (r_reg.flags[F_IRQ_ON] ? 16'hffff : 16'h0001);
      end else if (g == 1) begin : gen_ext1
        assign grp_vec[g] = ext_lines[15:0] & r_reg.emask &
          {16{r_reg.flags[F_IRQ_ON]}};
      end else begin : gen_extn
        assign grp_vec[g] = ext_lines[(g-1)*16 +: 16] &
          {16{r_reg.flags[F_IRQ_ON] & r_reg.egrp[g-1]}};
      end
      assign grp_any[g] = |grp_vec[g];
    end
  endgenerate

  // RULE_21 group zero first, then external groups in order
  logic irq_hit;
  logic [8:0] irq_line;
  always_comb begin
    irq_hit = 1'b0;
    irq_line = 9'h000;
    for (int k = 16; k >= 0; k--) begin
      if (grp_any[k]) begin
        irq_hit = 1'b1;
        irq_line = 9'(k * 16) + 9'(first_set(grp_vec[k]));
      end
    end
  end

  // Interrupt location: internal block, then external block
  logic [15:0] irq_vec;
  assign irq_vec = (irq_line < 9'h010) ? INT_VEC + 16'(irq_line) :
    EXT_VEC + 16'(irq_line - 9'h010);

  // RULE_15 accumulator sign flags from datapath result
  logic res_zero;
  assign res_zero = (exec_res.acc == 32'h0000_0000);

  logic apb_wr;
  logic apb_done;
  assign apb_done = psel & penable & r_reg.pready;
  assign apb_wr = apb_done & pwrite;

  logic [3:0] fsel;
  logic ftest;
  assign fsel = addr_part[3:0];
  // RULE_14 complement test via modifier bit
  assign ftest = r_reg.flags[fsel] ^ cmd_code[MOD_CPL];

  always_comb begin
    r_next = r_reg;
    r_next.exec_start = 1'b0;
    r_next.io_strobe = 1'b0;
    r_next.int_ack = 1'b0;

    case (r_reg.st)
      S_IDLE: begin
        if (r_reg.run) begin
          r_next.st = S_INTCHK;
        end
      end
      // RULE_22 break in only between instructions
      S_INTCHK: begin
        if (!r_reg.run) begin
          r_next.st = S_IDLE;
        end else begin
          r_next.st = S_FETCH;
          r_next.mem_req = 1'b1;
          r_next.mem_we = 1'b0;
          r_next.mem_addr = r_reg.next_pc;
          r_next.trap = 1'b0;
          // Trap instruction itself is not interruptible
          if (irq_hit && !r_reg.trap) begin
            r_next.mem_addr = irq_vec;
            r_next.trap = 1'b1;
            r_next.int_ack = 1'b1;
            r_next.int_id = irq_line;
          end
        end
      end
      // RULE_02 fetch into opword, advance next_pc
      S_FETCH: begin
        if (!r_reg.mem_req) begin
          // Parity refetch, one idle cycle after the ack
          r_next.mem_req = 1'b1;
        end else if (mem_ack) begin
          r_next.mem_req = 1'b0;
          r_next.opword = mem_rdata;
          r_next.ea = mem_rdata[ADDR_LSB +: 16];
          r_next.xsel = mem_rdata[XSEL_LSB +: 3];
          r_next.ind = mem_rdata[IND_BIT];
          r_next.st = S_INDEX;
          if (!r_reg.trap) begin
            r_next.next_pc = r_reg.next_pc + 16'h0001;
          end
          // RULE_22 fetch parity interrupts before execution
          if (mem_parity_err && r_reg.flags[F_IRQ_ON] &&
              r_reg.imask[LINE_PARITY] && !r_reg.trap) begin
            r_next.next_pc = r_reg.next_pc;
            r_next.mem_addr = INT_VEC + 16'(LINE_PARITY);
            r_next.trap = 1'b1;
            r_next.int_ack = 1'b1;
            r_next.int_id = 9'(LINE_PARITY);
            r_next.st = S_FETCH;
          end
        end
      end
      S_INDEX: begin
        // RULE_09 selector zero skips modification
        if (r_reg.xsel == 3'h0) begin
          r_next.st = r_reg.ind ? S_INDIR : S_DISP;
        end else if (r_reg.xsel == 3'h1) begin
          // RULE_08 accumulator serves as the first index
          r_next.ea = r_reg.ea + acc_index;
          r_next.st = r_reg.ind ? S_INDIR : S_DISP;
        end else if (!r_reg.mem_req) begin
          r_next.mem_req = 1'b1;
          r_next.mem_we = 1'b0;
          r_next.mem_addr = 16'(r_reg.xsel);
        end else if (mem_ack) begin
          // RULE_08 two's complement index sum
          r_next.mem_req = 1'b0;
          r_next.ea = r_reg.ea + mem_rdata[15:0];
          r_next.st = r_reg.ind ? S_INDIR : S_DISP;
        end
      end
      // RULE_07 chain indirect words until the bit clears
      S_INDIR: begin
        if (!r_reg.mem_req) begin
          r_next.mem_req = 1'b1;
          r_next.mem_we = 1'b0;
          r_next.mem_addr = r_reg.ea;
        end else if (mem_ack) begin
          r_next.mem_req = 1'b0;
          r_next.ea = mem_rdata[ADDR_LSB +: 16];
          r_next.ind = mem_rdata[IND_BIT];
          // RULE_10 each level is indexed again
          r_next.xsel = mem_rdata[XSEL_LSB +: 3];
          r_next.st = S_INDEX;
        end
      end
      // RULE_11 class and basic op with modifier bits
      S_DISP: begin
        r_next.st = S_INTCHK;
        r_next.cmd.command_code = cmd_code;
        r_next.cmd.eff_addr = r_reg.ea;
        // RULE_05 byte position from command bits
        r_next.cmd.byte_pos = basic[4:0];
        // RULE_12 unnormalized and save modifiers
        r_next.cmd.unnorm = cmd_code[MOD_UNNORM];
        r_next.cmd.save_acc = cmd_code[MOD_SAVE];
        case (cls)
          CLS_ARITH, CLS_LOGIC: begin
            if (cmd_code[MOD_IMM]) begin
              // RULE_03 effective address is the operand
              // RULE_04 sign extended two's complement
              r_next.cmd.operand = {{16{r_reg.ea[15]}}, r_reg.ea};
              r_next.exec_start = 1'b1;
              r_next.st = S_EXEC;
            end else begin
              r_next.mem_req = 1'b1;
              r_next.mem_we = 1'b0;
              r_next.mem_addr = r_reg.ea;
              r_next.st = S_OPND;
            end
          end
          CLS_FLAG: begin
            case (basic)
              // RULE_14 branch on tested flag
              OP_TEST: begin
                if (ftest) begin
                  r_next.next_pc = r_reg.ea;
                end
              end
              OP_SETF: r_next.flags[fsel] = 1'b1;
              OP_RSTF: r_next.flags[fsel] = 1'b0;
              // RULE_19 store flags to memory
              OP_STF: begin
                r_next.mem_req = 1'b1;
                r_next.mem_we = 1'b1;
                r_next.mem_addr = r_reg.ea;
                r_next.mem_wdata = {16'h0000, r_reg.flags};
                r_next.st = S_WRITE;
              end
              OP_LDF: begin
                r_next.mem_req = 1'b1;
                r_next.mem_we = 1'b0;
                r_next.mem_addr = r_reg.ea;
                r_next.st = S_OPND;
              end
              // RULE_18 null reports a high sense line
              OP_SENSE: r_next.flags[F_NULL] = sense_level;
              default: r_next.st = S_INTCHK;
            endcase
          end
          default: begin
            case (basic)
              // RULE_06 effective address names the line
              OP_FUNC: begin
                r_next.io_strobe = 1'b1;
                // RULE_17 busy line lands in wait_state
                r_next.flags[F_WAIT] = io_busy;
              end
              // Link stores return address, enters ea plus one
              OP_LINK: begin
                r_next.mem_req = 1'b1;
                r_next.mem_we = 1'b1;
                r_next.mem_addr = r_reg.ea;
                r_next.mem_wdata = {16'h0000, r_reg.next_pc};
                r_next.next_pc = r_reg.ea + 16'h0001;
                r_next.st = S_WRITE;
              end
              default: r_next.st = S_INTCHK;
            endcase
          end
        endcase
      end
      S_OPND: begin
        if (mem_ack) begin
          r_next.mem_req = 1'b0;
          if (cls == CLS_FLAG) begin
            r_next.flags = mem_rdata[15:0];
            r_next.st = S_INTCHK;
          end else begin
            r_next.cmd.operand = mem_rdata;
            r_next.exec_start = 1'b1;
            r_next.st = S_EXEC;
          end
        end
      end
      // RULE_13 flags settle as the instruction ends
      S_EXEC: begin
        if (exec_done) begin
          r_next.flags[F_NULL] = res_zero;
          r_next.flags[F_POS] = !exec_res.acc[31] && !res_zero;
          r_next.flags[F_NEG] = exec_res.acc[31];
          // RULE_16 sticky excess, carry copied
          r_next.flags[F_EXCESS] = r_reg.flags[F_EXCESS] |
            exec_res.overflow;
          r_next.flags[F_MSB_OUT] = exec_res.carry;
          r_next.st = S_INTCHK;
        end
      end
      S_WRITE: begin
        if (mem_ack) begin
          r_next.mem_req = 1'b0;
          r_next.mem_we = 1'b0;
          r_next.st = S_INTCHK;
        end
      end
      default: r_next.st = S_IDLE;
    endcase

    // APB: answer prepared in setup, completed in first access cycle
    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;
    if (psel && !penable) begin
      r_next.pready = 1'b1;
      r_next.prdata = 32'h0000_0000;
      case (paddr)
        A_CTRL: r_next.prdata = {31'h0, r_reg.run};
        A_PC: r_next.prdata = {16'h0, r_reg.next_pc};
        A_OPWORD: r_next.prdata = r_reg.opword;
        A_FLAGS: r_next.prdata = {16'h0, r_reg.flags};
        A_IMASK: r_next.prdata = {16'h0, r_reg.imask};
        A_EMASK: r_next.prdata = {16'h0, r_reg.emask};
        A_EGRP: r_next.prdata = {16'h0, r_reg.egrp};
        A_STATUS: r_next.prdata = {19'h0, r_reg.int_id,
          r_reg.st};
        default: r_next.pslverr = 1'b1;
      endcase
    end
    if (apb_wr) begin
      case (paddr)
        A_CTRL: r_next.run = pwdata[0];
        A_PC: begin
          // Only a stopped sequencer may be redirected
          if (r_reg.st == S_IDLE) begin
            r_next.next_pc = pwdata[15:0];
          end
        end
        // Hardware sets win over the write
        A_FLAGS: r_next.flags = pwdata[15:0] |
          (r_next.flags & ~r_reg.flags);
        A_IMASK: r_next.imask = pwdata[15:0];
        A_EMASK: r_next.emask = pwdata[15:0];
        A_EGRP: r_next.egrp = pwdata[15:0];
        default: r_next.run = r_next.run;
      endcase
    end
    // RULE_17 console sets programmer flags; set wins
    r_next.flags[F_PROG_LSB +: 8] = r_next.flags[F_PROG_LSB +: 8] |
      console_flags;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_reg <= '0;
      r_reg.st <= S_IDLE;
      r_reg.next_pc <= PC_RST;
      r_reg.flags <= FLAGS_RST;
      r_reg.imask <= MASK_RST;
      r_reg.emask <= MASK_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign mem_req = r_reg.mem_req;
  assign mem_we = r_reg.mem_we;
  assign mem_addr = r_reg.mem_addr;
  assign mem_wdata = r_reg.mem_wdata;
  assign exec_start = r_reg.exec_start;
  assign exec_cmd = r_reg.cmd;
  assign io_strobe = r_reg.io_strobe;
  assign io_addr = r_reg.ea;
  assign int_ack = r_reg.int_ack;
  assign int_id = r_reg.int_id;
endmodule : instruction_control_unit

// file: sim/icu_mem_model.sv
// Memory bank and arithmetic datapath model facing the control unit
`timescale 1ns/1ps
module icu_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Datapath
  input wire logic exec_start,
  output logic exec_done,
  output icu_pkg::exec_res_s exec_res
);
  import icu_pkg::*;
  logic [31:0] mem [0:65535];
  exec_res_s res_tab [0:3];
  logic [31:0] st;
  logic [1:0] gap;
  logic [1:0] cnt;
  logic busy;
  int n_exec;
  initial begin
    st = 32'h58;
    mem_ack = 1'h0;
    exec_done = 1'h0;
    mem_rdata = 32'h0;
    exec_res = '0;
    for (int i = 0; i < 65536; i++) mem[i] = 32'h0;
    for (int i = 0; i < 4; i++) res_tab[i] = '0;
  end
  // Answers vary in delay; idle data lines toggle so stale data is caught
  always @(posedge clk) begin
    st <= {st[30:0], st[31] ^ st[21] ^ st[1] ^ st[0]};
    mem_ack <= 1'h0;
    exec_done <= 1'h0;
    mem_rdata <= ~mem_rdata;
    exec_res <= exec_res_s'(~exec_res);
    if (sys_rst) begin
      gap <= 2'h0;
      busy <= 1'h0;
      n_exec <= 0;
    end else begin
      if (mem_req && !mem_ack) begin
        if (gap == 2'h0) begin
          mem_ack <= 1'h1;
          gap <= st[1:0];
          if (mem_we) mem[mem_addr] <= mem_wdata;
          else mem_rdata <= mem[mem_addr];
        end else begin
          gap <= gap - 2'h1;
        end
      end
      if (exec_start) begin
        busy <= 1'h1;
        cnt <= st[3:2];
      end else if (busy && cnt == 2'h0) begin
        exec_done <= 1'h1;
        exec_res <= res_tab[n_exec];
        busy <= 1'h0;
        if (n_exec < 3) n_exec <= n_exec + 1;
      end else if (busy) begin
        cnt <= cnt - 2'h1;
      end
    end
  end
endmodule : icu_mem_model

// file: sim/icu_checker.sv
// Port checker for the instruction control unit
`timescale 1ns/1ps
module icu_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus and memory
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic mem_parity_err,
  // Execution and interrupts
  input wire logic exec_start,
  input wire icu_pkg::exec_cmd_s exec_cmd,
  input wire logic [15:0] int_lines,
  input wire logic int_ack,
  input wire logic [8:0] int_id
);
  import icu_pkg::*;
  logic [15:0] lines_d;
  logic [15:0] vec_exp;
  logic par_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk) begin
    lines_d <= int_lines;
    par_d <= mem_parity_err;
    if (int_ack) vec_exp <= INT_VEC + 16'(int_id);
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_vec; ##[0:5] mem_req && !mem_we && mem_addr == vec_exp;
  endsequence
  AST_APB_ANSWER: assert property (s_setup |=> psel && pready)
    else $error("access phase not answered");
  AST_MEM_HOLD: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped early");
  AST_MEM_RELEASE: assert property (
    mem_req && mem_ack |=> !mem_req)
    else $error("memory request kept after answer");
  AST_EXEC_ONCE: assert property (
    exec_start |=> !exec_start && $stable(exec_cmd))
    else $error("command not steady after start");
  AST_IMM_SIGNED: assert property (
    exec_start && exec_cmd.command_code[MOD_IMM] && !exec_cmd.command_code[11]
    |-> exec_cmd.operand[31:16] == {16{exec_cmd.operand[15]}})
    else $error("immediate not sign extended");
  AST_BYTE_POS: assert property (
    exec_start |-> exec_cmd.byte_pos == exec_cmd.command_code[8:4])
    else $error("byte position not from command");
  AST_INT_CAUSE: assert property (
    int_ack && int_id < 9'h10 |-> lines_d[int_id[3:0]] ||
    (par_d && int_id == 9'(LINE_PARITY)))
    else $error("interrupt taken on quiet line");
  AST_VEC_FETCH: assert property (
    int_ack && int_id < 9'h10 |=> s_vec)
    else $error("vector not fetched");
endmodule : icu_checker
bind instruction_control_unit icu_checker icu_checker_i (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pready(pready), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_ack(mem_ack), .exec_start(exec_start),
  .mem_parity_err(mem_parity_err),
  .exec_cmd(exec_cmd), .int_lines(int_lines), .int_ack(int_ack),
  .int_id(int_id));

// file: sim/tb_instruction_control_unit.sv
// Self-checking bench of the instruction control unit
`timescale 1ns/1ps
module tb_instruction_control_unit;
  import icu_pkg::*;
  logic clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, par = 1'h0, pready, pslverr, mem_req, mem_we, mem_ack;
  logic exec_start, exec_done, io_strobe, int_ack, e, sense_level;
  logic [7:0] paddr = 8'h0, con;
  logic [8:0] int_id;
  logic [15:0] mem_addr, io_addr, acc_index, x2, tgt, imm;
  logic [15:0] int_lines = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, mem_wdata, mem_rdata, q;
  logic [31:0] seed = 32'h58;
  exec_cmd_s exec_cmd;
  exec_res_s exec_res;
  exec_res_s r [0:2];
  int n_mismatch = 0, n_tests = 0;
  always #25 clk = ~clk;
  instruction_control_unit instruction_control_unit_i (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_parity_err(par),
    .exec_start(exec_start), .exec_cmd(exec_cmd), .exec_done(exec_done),
    .exec_res(exec_res), .acc_index(acc_index), .io_strobe(io_strobe),
    .io_addr(io_addr), .sense_level(sense_level), .io_busy(1'h0),
    .int_lines(int_lines), .ext_lines(256'h0), .console_flags(con),
    .int_ack(int_ack), .int_id(int_id));
  icu_mem_model icu_mem_model_i (
    .clk(clk), .sys_rst(sys_rst), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .exec_start(exec_start),
    .exec_done(exec_done), .exec_res(exec_res));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] iw(logic [1:0] c, logic [5:0] b,
      logic [3:0] m, logic i, logic [2:0] x, logic [15:0] a);
    return {c, b, m, x, i, a};
  endfunction : iw
  // Flag word expected after a datapath result
  function automatic logic [31:0] fx(exec_res_s s, logic v);
    return {16'h0, con, 3'h0, s.carry, v, s.acc[31],
      !s.acc[31] && |s.acc, ~|s.acc};
  endfunction : fx
  task automatic put(input logic [15:0] a, input logic [31:0] d);
    icu_mem_model_i.mem[a] = d;
  endtask : put
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      $display("Error pready expected 1 seen 0");
    end
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  // Waits for exec start, memory write, io strobe or interrupt
  task automatic wait_ev(int k);
    int n;
    logic hit;
    n = 0;
    hit = 1'h0;
    while (!hit && n < 400) begin
      @(posedge clk);
      n++;
      case (k)
        0: hit = exec_start === 1'h1;
        1: hit = mem_req === 1'h1 && mem_we === 1'h1 && mem_ack === 1'h1;
        2: hit = io_strobe === 1'h1;
        default: hit = int_ack === 1'h1;
      endcase
    end
    if (!hit) begin
      n_mismatch++;
      $display("Error event %0d expected 1 seen 0", k);
    end
  endtask : wait_ev
  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  initial begin
    acc_index <= 16'(rnd());
    con <= 8'(rnd());
    sense_level <= 1'(rnd());
    x2 = 16'(rnd()) & 16'h007f;
    tgt = 16'(rnd());
    imm = 16'(rnd());
    for (int i = 0; i < 3; i++) r[i] = exec_res_s'({rnd(), 2'(rnd())});
    r[0].overflow = 1'h0;
    r[1].overflow = 1'h1;
    r[2] = '0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'h0;
    for (int i = 0; i < 3; i++) icu_mem_model_i.res_tab[i] = r[i];
    put(16'h0400, iw(CLS_ARITH, 6'h05, 4'h8, 1'h0, 3'h0, imm));
    put(16'h0401, iw(CLS_FLAG, OP_STF, 4'h0, 1'h0, 3'h0, 16'h0100));
    put(16'h0402, iw(CLS_ARITH, 6'h00, 4'h6, 1'h0, 3'h1, 16'h0010));
    put(16'h0403, iw(CLS_CTRL, OP_FUNC, 4'h0, 1'h1, 3'h2, 16'h0040));
    put(16'h0404, iw(CLS_CTRL, OP_LINK, 4'h0, 1'h0, 3'h0, 16'h0200));
    put(16'h0202, iw(CLS_FLAG, OP_STF, 4'h0, 1'h0, 3'h0, 16'h0101));
    put(16'h0203, iw(CLS_FLAG, OP_SENSE, 4'h0, 1'h0, 3'h0, 16'h0003));
    put(16'h0204, iw(CLS_FLAG, OP_STF, 4'h0, 1'h0, 3'h0, 16'h0102));
    put(16'h0205, iw(CLS_FLAG, OP_SETF, 4'h0, 1'h0, 3'h0, 16'h0006));
    put(16'h0002, {16'h0, x2});
    put(16'h0040 + x2, {16'h0, tgt});
    @(posedge clk);
    apb(1'h0, A_FLAGS, 32'h0);
    chk("flags", {16'h0, con, 8'h0}, q);
    apb(1'h0, 8'h20, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    apb(1'h1, A_OPWORD, 32'hffffffff);
    apb(1'h0, A_OPWORD, 32'h0);
    chk("opword", 32'h0, q);
    apb(1'h1, A_PC, 32'h400);
    apb(1'h0, A_PC, 32'h0);
    chk("pc", 32'h400, q);
    apb(1'h1, A_CTRL, 32'h1);
    wait_ev(0);
    chk("operand", {{16{imm[15]}}, imm}, exec_cmd.operand);
    chk("bytepos", 32'h5, 32'(exec_cmd.byte_pos));
    wait_ev(1);
    chk("stf", {16'h0100, 16'h0}, {mem_addr, 16'h0});
    chk("flags0", fx(r[0], 1'h0), mem_wdata);
    wait_ev(0);
    chk("ea", {16'h0, acc_index + 16'h10}, 32'(exec_cmd.eff_addr));
    chk("mods", 32'h3, {30'h0, exec_cmd.unnorm, exec_cmd.save_acc});
    wait_ev(2);
    chk("io", 32'(tgt), 32'(io_addr));
    wait_ev(1);
    chk("link", {16'h0200, 16'h0405}, {mem_addr, mem_wdata[15:0]});
    wait_ev(1);
    chk("sticky", fx(r[2], 1'h1), mem_wdata);
    wait_ev(1);
    chk("sense", 32'(sense_level), 32'(mem_wdata[0]));
    apb(1'h1, A_IMASK, 32'h9);
    int_lines <= 16'h000b;
    wait_ev(3);
    chk("int0", 32'h0, 32'(int_id));
    int_lines <= 16'h000a;
    wait_ev(3);
    chk("int3", 32'h3, 32'(int_id));
    int_lines <= 16'h0;
    apb(1'h0, A_FLAGS, 32'h0);
    chk("irq_on", 32'h1, 32'(q[F_IRQ_ON]));
    apb(1'h1, A_IMASK, 32'h2);
    par <= 1'h1;
    wait_ev(3);
    par <= 1'h0;
    chk("parity", 32'h1, 32'(int_id));
    final_report();
  end
endmodule : tb_instruction_control_unit
